// ---- mss_pkg.sv ----
// Behaviour
// - Three modes: light-load, forced fixed, synchronized
// - Light-load: pulse-frequency operation with diode emulation
// - Forced fixed: no diode emulation, full frequency
// - Synchronized: clock follows external sync frequency
// - Synchronized behaves as forced fixed mode
// - Level decode: ground, middle, top bands
// - Level control never locks to external clock
// - Level mode applied after settling time
// - Spread spectrum off during frequency foldback
// - Resistor strap fixes light-load without spread
// - Fourth valid pulse enters pulse control
// - Pulse control held until restart
// - Pulse decode: levels, clock, double pulse
// - Pulse-control mode change after settling time
// - Sync mode after 2048 valid cycles
// - Constant level: mode by level, spread on unless a double pulse came before
// - Frequency steps at 2048, intermediate cycle
// - Phase adjusts until sync edges align
// - Spread on at a train's third rising edge, off at step
// - Lock deferred during reduced-frequency operation
package mss_pkg;

    localparam int MSS_CNT_W = 16;

    // Times in ns and the pclk rate
    localparam int MSS_PCLK_NS         = 100;
    localparam int MSS_T_MODE_NS       = 100000;
    localparam int MSS_MODE_CYC        = (MSS_T_MODE_NS + MSS_PCLK_NS - 1) / MSS_PCLK_NS;
    localparam int MSS_SYNC_PULSES     = 2048;
    localparam int MSS_ENTRY_PULSES    = 4;
    localparam int MSS_PHASE_CYC       = 32;

    // Pulse validity limits, in pclk cycles
    localparam int MSS_PER_MIN_RST     = 4;
    localparam int MSS_PER_MAX_RST     = 50;
    localparam int MSS_HI_MIN_RST      = 1;
    localparam int MSS_HI_MAX_RST      = 40;
    localparam int MSS_LO_MIN_RST      = 1;
    localparam int MSS_LO_MAX_RST      = 40;

    // APB register byte offsets
    localparam logic [7:0] MSS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] MSS_STATUS_OFS = 8'h04;
    localparam logic [7:0] MSS_PER_OFS    = 8'h08;
    localparam logic [7:0] MSS_HI_OFS     = 8'h0c;
    localparam logic [7:0] MSS_LO_OFS     = 8'h10;
    localparam logic [7:0] MSS_SYNCP_OFS  = 8'h14;

    // Pin level class from the analog comparators
    typedef enum logic [1:0] {MSS_LVL_GND, MSS_LVL_MID, MSS_LVL_TOP} mss_level_type;

    typedef enum logic [1:0] {MSS_MODE_LIGHT, MSS_MODE_FIXED, MSS_MODE_SYNC} mss_mode_type;

    // Mode outputs that travel together to the power stage
    typedef struct packed {
        mss_mode_type mode;
        logic         pfm_en;
        logic         diode_emul;
        logic         spread_en;
        logic         freq_step;
        logic         phase_adj;
        logic         locked;
    } mss_ctrl_type;

    typedef struct packed {
        logic [MSS_CNT_W-1:0] min;
        logic [MSS_CNT_W-1:0] max;
    } mss_limit_type;

endpackage

// ---- mss_controller.sv ----
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module mss_controller
    import mss_pkg::*;
#(
    parameter int MODE_CYC    = MSS_MODE_CYC,
    parameter int SYNC_PULSES = MSS_SYNC_PULSES
)
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          mode_sync,
    input  wire mss_level_type level_class,
    input  wire logic          strap_100k,
    input  wire logic          reduced_freq,
    input  wire logic          freq_foldback,
    input  wire logic          sw_rise,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output mss_ctrl_type       ctrl
);

    // Two-stage synchronisers for pins and analog classes
    logic [2:0]    pin_sync;
    mss_level_type lvl_s1;
    mss_level_type lvl_s2;
    logic [1:0]    strap_sync;
    logic [1:0]    red_sync;
    logic [1:0]    fold_sync;
    logic [1:0]    swr_sync;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync   <= 3'h0;
            lvl_s1     <= MSS_LVL_GND;
            lvl_s2     <= MSS_LVL_GND;
            strap_sync <= 2'h0;
            red_sync   <= 2'h0;
            fold_sync  <= 2'h0;
            swr_sync   <= 2'h0;
        end
        else
        begin
            pin_sync   <= {pin_sync[1:0], mode_sync};
            lvl_s1     <= level_class;
            lvl_s2     <= lvl_s1;
            strap_sync <= {strap_sync[0], strap_100k};
            red_sync   <= {red_sync[0], reduced_freq};
            fold_sync  <= {fold_sync[0], freq_foldback};
            swr_sync   <= {swr_sync[0], sw_rise};
        end
    end

    // Edge detection reads only the second and third stages
    logic pin;
    logic rise;
    logic fall;
    assign pin  = pin_sync[1];
    assign rise = pin_sync[1] & ~pin_sync[2];
    assign fall = ~pin_sync[1] & pin_sync[2];

    // Strap latched once, only after its synchroniser has refilled past reset
    logic [1:0] strap_wait;
    logic       strap_fixed;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_wait  <= 2'h0;
            strap_fixed <= 1'b0;
        end
        else
        begin
            if (strap_wait != 2'h3)
                strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h2)
                strap_fixed <= strap_sync[1];
        end
    end

    // Software-set pulse limits
    mss_limit_type per_lim;
    mss_limit_type hi_lim;
    mss_limit_type lo_lim;
    logic          sw_force_light;

    // Pulse timing and validation
    logic [MSS_CNT_W-1:0] hi_cnt;
    logic [MSS_CNT_W-1:0] lo_cnt;
    logic [MSS_CNT_W-1:0] per_cnt;
    logic [2:0]           valid_cnt;
    logic                 pulse_ok;
    logic                 pulse_bad;
    logic                 idle_to;
    logic                 hi_ok;
    logic                 lo_ok;
    logic                 per_ok;

    assign hi_ok  = (hi_cnt >= hi_lim.min) && (hi_cnt <= hi_lim.max);
    assign lo_ok  = (lo_cnt >= lo_lim.min) && (lo_cnt <= lo_lim.max);
    assign per_ok = (per_cnt >= per_lim.min) && (per_cnt <= per_lim.max);
    // A period closes at each rising edge
    assign pulse_ok  = rise && hi_ok && lo_ok && per_ok;
    assign pulse_bad = rise && !(hi_ok && lo_ok && per_ok);
    assign idle_to   = (per_cnt > per_lim.max);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_cnt  <= '0;
            lo_cnt  <= '0;
            per_cnt <= '0;
        end
        else
        begin
            if (rise)
            begin
                per_cnt <= MSS_CNT_W'(1);
                hi_cnt  <= MSS_CNT_W'(1);
            end
            else
            begin
                if (per_cnt != '1)
                    per_cnt <= per_cnt + 1'b1;
                if (pin && hi_cnt != '1)
                    hi_cnt <= hi_cnt + 1'b1;
            end
            if (fall)
                lo_cnt <= MSS_CNT_W'(1);
            else if (!pin && !rise && lo_cnt != '1)
                lo_cnt <= lo_cnt + 1'b1;
        end
    end

    // Count of back-to-back valid periods; a bad one restarts
    logic pulse_ctl;
    logic [MSS_CNT_W-1:0] sync_pulses;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_cnt   <= 3'h0;
            sync_pulses <= '0;
        end
        else if (pulse_bad || idle_to)
        begin
            valid_cnt   <= 3'h0;
            sync_pulses <= '0;
        end
        else if (pulse_ok)
        begin
            if (valid_cnt != 3'h7)
                valid_cnt <= valid_cnt + 3'h1;
            if (sync_pulses != '1)
                sync_pulses <= sync_pulses + 1'b1;
        end
    end

    // Pulse control entered once, left only by reset; a train's first rise
    // closes no valid period, so its fourth pulse closes the third valid period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_ctl <= 1'b0;
        else if (pulse_ok && valid_cnt == 3'(MSS_ENTRY_PULSES - 2) && !strap_fixed)
            pulse_ctl <= 1'b1;
    end

    // Constant-level settling timer, restarted by any pin change or, outside pulse control, any class change
    logic [MSS_CNT_W-1:0] settle_cnt;
    logic                 settled;
    logic                 lvl_chg;
    mss_level_type        lvl_hold;
    // Under pulse control only the pin's edges count; the band is ignored
    assign lvl_chg = rise || fall || (!pulse_ctl && lvl_s2 != lvl_hold);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle_cnt <= '0;
            lvl_hold   <= MSS_LVL_GND;
        end
        else
        begin
            lvl_hold <= lvl_s2;
            if (lvl_chg)
                settle_cnt <= '0;
            else if (settle_cnt < MSS_CNT_W'(MODE_CYC))
                settle_cnt <= settle_cnt + 1'b1;
        end
    end
    assign settled = !lvl_chg && (settle_cnt == MSS_CNT_W'(MODE_CYC));

    // Double pulse: second pulse of a fresh train ends with no third after it;
    // judged at falls, so a trailing rise into a high level keeps the mark
    logic dbl_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dbl_seen <= 1'b0;
        else if (pulse_bad)
            dbl_seen <= 1'b0;
        else if (fall)
            dbl_seen <= (valid_cnt == 3'h1);
    end

    // Mode, spread spectrum and lock sequencing
    mss_mode_type mode;
    logic         spread_req;
    logic         locked;
    logic         step_pulse;
    logic [5:0]   phase_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode       <= MSS_MODE_LIGHT;
            spread_req <= 1'b1;
            locked     <= 1'b0;
            step_pulse <= 1'b0;
        end
        else
        begin
            step_pulse <= 1'b0;
            if (strap_fixed || sw_force_light)
            begin
                mode       <= MSS_MODE_LIGHT;
                spread_req <= 1'b0;
                locked     <= 1'b0;
            end
            else if (!pulse_ctl)
            begin
                locked <= 1'b0;
                if (settled)
                begin
                    case (lvl_s2)
                        MSS_LVL_GND:
                        begin
                            mode       <= MSS_MODE_LIGHT;
                            spread_req <= 1'b1;
                        end
                        MSS_LVL_MID:
                        begin
                            mode       <= MSS_MODE_FIXED;
                            spread_req <= 1'b1;
                        end
                        MSS_LVL_TOP:
                        begin
                            mode       <= MSS_MODE_FIXED;
                            spread_req <= 1'b0;
                        end
                        default:
                        begin
                            mode       <= MSS_MODE_LIGHT;
                            spread_req <= 1'b1;
                        end
                    endcase
                end
            end
            else if (settled)
            begin
                mode       <= pin ? MSS_MODE_FIXED : MSS_MODE_LIGHT;
                spread_req <= !dbl_seen;
                locked     <= 1'b0;
            end
            else if (rise && sync_pulses == MSS_CNT_W'(1))
                spread_req <= 1'b1;
            else if (!locked && !red_sync[1] && sync_pulses >= MSS_CNT_W'(SYNC_PULSES))
            begin
                mode       <= MSS_MODE_SYNC;
                locked     <= 1'b1;
                step_pulse <= 1'b1;
                spread_req <= 1'b0;
            end
            else if (locked && (pulse_bad || idle_to))
                locked <= 1'b0;
        end
    end

    // Phase alignment window after the step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_cnt <= 6'h0;
        else if (step_pulse)
            phase_cnt <= 6'(MSS_PHASE_CYC);
        else if (!locked)
            phase_cnt <= 6'h0;
        else if (rise && phase_cnt != 6'h0 && !swr_sync[1])
            phase_cnt <= phase_cnt - 6'h1;
        else if (rise && swr_sync[1])
            phase_cnt <= 6'h0;
    end

    // Outputs to the power stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= '{MSS_MODE_LIGHT, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        else
        begin
            ctrl.mode       <= mode;
            ctrl.pfm_en     <= (mode == MSS_MODE_LIGHT);
            ctrl.diode_emul <= (mode == MSS_MODE_LIGHT);
            ctrl.spread_en  <= spread_req && !fold_sync[1];
            ctrl.freq_step  <= step_pulse;
            ctrl.phase_adj  <= (phase_cnt != 6'h0);
            ctrl.locked     <= locked;
        end
    end

    // APB slave, zero wait states
    logic wr_en;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            per_lim        <= '{MSS_CNT_W'(MSS_PER_MIN_RST), MSS_CNT_W'(MSS_PER_MAX_RST)};
            hi_lim         <= '{MSS_CNT_W'(MSS_HI_MIN_RST), MSS_CNT_W'(MSS_HI_MAX_RST)};
            lo_lim         <= '{MSS_CNT_W'(MSS_LO_MIN_RST), MSS_CNT_W'(MSS_LO_MAX_RST)};
            sw_force_light <= 1'b0;
        end
        else if (wr_en)
        begin
            case (paddr)
                MSS_CTRL_OFS: sw_force_light <= pwdata[0];
                MSS_PER_OFS:  per_lim <= pwdata;
                MSS_HI_OFS:   hi_lim  <= pwdata;
                MSS_LO_OFS:   lo_lim  <= pwdata;
                default:      sw_force_light <= sw_force_light;
            endcase
        end
    end

    // Read mux and error on unmapped address
    logic mapped;
    always_comb
    begin
        mapped = 1'b1;
        case (paddr)
            MSS_CTRL_OFS:   prdata = {31'h0, sw_force_light};
            MSS_STATUS_OFS: prdata = {23'h0, strap_fixed, valid_cnt, ctrl.spread_en,
                                      locked, pulse_ctl, mode};
            MSS_PER_OFS:    prdata = per_lim;
            MSS_HI_OFS:     prdata = hi_lim;
            MSS_LO_OFS:     prdata = lo_lim;
            MSS_SYNCP_OFS:  prdata = {16'h0, sync_pulses};
            default:
            begin
                prdata = 32'h0;
                mapped = 1'b0;
            end
        endcase
    end
    assign pslverr = psel && penable && !mapped;

endmodule

// ---- mss_host_model.sv ----
`timescale 1ns/1ps
module mss_host_model
    import mss_pkg::*;
(
    input  wire logic pclk,
    output logic      mode_sync
);
    // Pin rests low until the host speaks
    initial mode_sync = 1'b0;

    // Train of n pulses, 800 ns period, half high; then pin rests at idl
    // Timing sits inside the reset limits so every period the train closes counts as valid
    task automatic train(input int n, input logic idl);
        repeat (n)
        begin
            @(posedge pclk);
            mode_sync <= 1'b1;
            repeat (4) @(posedge pclk);
            mode_sync <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        @(posedge pclk);
        mode_sync <= idl;
    endtask
endmodule

// ---- mss_controller_chk.sv ----
`timescale 1ns/1ps
module mss_controller_chk
    import mss_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         reduced_freq,
    input wire logic         freq_foldback,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [7:0]   paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire mss_ctrl_type ctrl
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Mode code keeps to its three values
    AST_MODE_LEGAL: assert property (ctrl.mode != 2'h3)
        else $error("mode code out of range");
    AST_LIGHT_DIODE: assert property (
        ctrl.mode == MSS_MODE_LIGHT |-> ctrl.pfm_en && ctrl.diode_emul)
        else $error("light mode without diode emulation");
    AST_FIXED_FULL: assert property (
        ctrl.mode == MSS_MODE_FIXED |-> !ctrl.pfm_en && !ctrl.diode_emul)
        else $error("fixed mode with diode emulation");
    AST_SYNC_AS_FIXED: assert property (
        ctrl.mode == MSS_MODE_SYNC |-> !ctrl.diode_emul && !ctrl.spread_en)
        else $error("sync mode not run as fixed without spread");
    // Foldback lets three edges pass for the two synchroniser stages and the output register
    AST_FOLD_SPREAD: assert property (freq_foldback[*4] |-> !ctrl.spread_en)
        else $error("spread on during foldback");
    AST_STEP_ONCE: assert property (
        ctrl.freq_step |=> !ctrl.freq_step && ctrl.mode == MSS_MODE_SYNC)
        else $error("frequency step not a single pulse in sync");
    AST_LOCK_DEFER: assert property (reduced_freq[*5] |-> !$rose(ctrl.locked))
        else $error("lock taken at reduced frequency");
    AST_LOCK_SPREAD: assert property (ctrl.locked |-> !ctrl.spread_en)
        else $error("spread on while locked");
    // Zero-wait slave; error only off a word boundary or beyond the last register
    AST_APB_ANSWER: assert property (psel && penable |->
        pready && (pslverr == ((paddr[1:0] != 2'h0) || (paddr > MSS_SYNCP_OFS))))
        else $error("bad bus answer");
endmodule

bind mss_controller mss_controller_chk u_chk (
    .pclk         (pclk),
    .presetn      (presetn),
    .reduced_freq (reduced_freq),
    .freq_foldback(freq_foldback),
    .psel         (psel),
    .penable      (penable),
    .paddr        (paddr),
    .pready       (pready),
    .pslverr      (pslverr),
    .ctrl         (ctrl)
);

// ---- mss_controller_test.sv ----
`timescale 1ns/1ps
module mss_controller_test
    import mss_pkg::*;
;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          mode_sync;
    mss_level_type level_class = MSS_LVL_GND;
    logic          strap_100k = 1'b0;
    logic          reduced_freq = 1'b0;
    logic          freq_foldback = 1'b0;
    logic          sw_rise = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    mss_ctrl_type  ctrl;
    logic [31:0]   q;
    logic          e;
    int            n_mismatch = 0;
    int            compares = 0;
    int            cyc = 0;
    int            n_lock = 0;
    int            n_step = 0;
    int            n_adj = 0;

    always #50 pclk = ~pclk;

    mss_host_model u_host (.pclk(pclk), .mode_sync(mode_sync));

    // Short counts keep the run brief
    mss_controller #(.MODE_CYC(20), .SYNC_PULSES(8)) u_dut (
        .pclk         (pclk),
        .presetn      (presetn),
        .mode_sync    (mode_sync),
        .level_class  (level_class),
        .strap_100k   (strap_100k),
        .reduced_freq (reduced_freq),
        .freq_foldback(freq_foldback),
        .sw_rise      (sw_rise),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .ctrl         (ctrl)
    );

    // Event counters; sw_rise stays low until the phase search is to end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        n_lock <= n_lock + ctrl.locked;
        n_step <= n_step + ctrl.freq_step;
        n_adj <= n_adj + ctrl.phase_adj;
        if (cyc == 6000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    // Mode with the drive flags that the rules tie to it
    task automatic cm(input mss_mode_type m, input logic s);
        logic lt;
        lt = (m == MSS_MODE_LIGHT);
        chk({ctrl.mode, ctrl.pfm_en, ctrl.diode_emul, ctrl.spread_en}, {m, lt, lt, s});
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; an edge first so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_level;
        hold(3);
        cm(MSS_MODE_LIGHT, 1'b1);
        u_host.train(0, 1'b1);
        level_class <= MSS_LVL_MID;
        hold(10);
        cm(MSS_MODE_LIGHT, 1'b1);
        hold(20);
        cm(MSS_MODE_FIXED, 1'b1);
        freq_foldback <= 1'b1;
        hold(5);
        cm(MSS_MODE_FIXED, 1'b0);
        freq_foldback <= 1'b0;
        hold(5);
        cm(MSS_MODE_FIXED, 1'b1);
        level_class <= MSS_LVL_TOP;
        hold(30);
        cm(MSS_MODE_FIXED, 1'b0);
        level_class <= MSS_LVL_MID;
        hold(30);
    endtask

    task automatic t_apb;
        apb(1'b0, MSS_PER_OFS, 32'h0);
        chk(q, 32'h0004_0032);
        // Tight period limit so a pause ends a train before the level settles
        apb(1'b1, MSS_PER_OFS, 32'h0004_000c);
        apb(1'b0, MSS_PER_OFS, 32'h0);
        chk(q, 32'h0004_000c);
        apb(1'b1, MSS_CTRL_OFS, 32'h1);
        hold(3);
        cm(MSS_MODE_LIGHT, 1'b0);
        apb(1'b1, MSS_CTRL_OFS, 32'h0);
        hold(3);
        cm(MSS_MODE_FIXED, 1'b1);
        apb(1'b1, MSS_LO_OFS, 32'h0002_0028);
        apb(1'b0, MSS_LO_OFS, 32'h0);
        chk(q, 32'h0002_0028);
        apb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
    endtask

    // Class is mid, then top, so a light result proves the pin decode took over
    task automatic t_pulse;
        u_host.train(0, 1'b0);
        apb(1'b0, MSS_STATUS_OFS, 32'h0);
        chk(q[2], 1'b0);
        u_host.train(4, 1'b0);
        apb(1'b0, MSS_STATUS_OFS, 32'h0);
        chk(q[2], 1'b1);
        hold(30);
        cm(MSS_MODE_LIGHT, 1'b1);
        u_host.train(2, 1'b1);
        hold(30);
        cm(MSS_MODE_FIXED, 1'b0);
        u_host.train(0, 1'b0);
        u_host.train(2, 1'b0);
        hold(10);
        cm(MSS_MODE_FIXED, 1'b0);
        hold(20);
        cm(MSS_MODE_LIGHT, 1'b0);
        level_class <= MSS_LVL_TOP;
        hold(30);
        cm(MSS_MODE_LIGHT, 1'b0);
    endtask

    task automatic t_sync;
        int n0;
        reduced_freq <= 1'b1;
        n0 = n_lock;
        u_host.train(16, 1'b0);
        chk(n_lock - n0, 0);
        reduced_freq <= 1'b0;
        n0 = n_step;
        u_host.train(12, 1'b0);
        chk(n_adj > 0, 1);
        sw_rise <= 1'b1;
        u_host.train(4, 1'b0);
        chk(n_step - n0, 1);
        chk(ctrl.phase_adj, 1'b0);
        chk(ctrl.locked, 1'b1);
        cm(MSS_MODE_SYNC, 1'b0);
        hold(30);
        cm(MSS_MODE_LIGHT, 1'b1);
    endtask

    // Second reset with the strap fitted; class changes must not move it
    task automatic t_strap;
        presetn <= 1'b0;
        strap_100k <= 1'b1;
        level_class <= MSS_LVL_MID;
        hold(6);
        presetn <= 1'b1;
        hold(30);
        cm(MSS_MODE_LIGHT, 1'b0);
        level_class <= MSS_LVL_TOP;
        hold(30);
        cm(MSS_MODE_LIGHT, 1'b0);
    endtask

    initial
    begin
        hold(6);
        presetn <= 1'b1;
        t_level();
        t_apb();
        t_pulse();
        t_sync();
        t_strap();
        end_sim();
    end
endmodule
